// ===== test/dsudbg_probe.sv
/*
  Serial probe model: clocks the link only inside frames.
  Assumes the bench wires its outputs to the design's link pins.
*/
`timescale 1ns/10ps
module dsudbg_probe
(
  // link clock and data line
  output logic swclk,
  output logic swdio_in,
  input wire logic swdio_out,
  input wire logic swdio_oe
);
  logic pd;
  // line level from both drivers
  assign swdio_in = swdio_oe ? swdio_out : pd;
  initial
  begin
    swclk = 1'b0;
    pd = 1'b1;
  end
  task automatic tick(input logic b);
  begin
    pd = b;
    #32 swclk = 1'b1;
    #32 swclk = 1'b0;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic frame(input logic rnw, output logic [39:0] got, output logic [5:0] n);
    logic [7:0] req;
    logic seen;
  begin
    // parity is even over apndp, rnw, a2 and a3; the start bit is not counted
    req = {2'b10, ~rnw, 2'b10, rnw, 2'b01};
    got = '0;
    n = '0;
    seen = 1'b0;
    for (int i = 0; i < 52; i++)
      tick(1'b1);
    tick(1'b0);
    for (int i = 0; i < 8; i++)
      tick(req[i]);
    // released line toggles so a stale level is never read
    for (int i = 0; i < 45 && !(seen && !swdio_oe); i++)
    begin
      tick(~pd);
      if (swdio_oe)
      begin
        got[n] = swdio_out;
        n++;
        seen = 1'b1;
      end
    end
  end
  endtask
endmodule // dsudbg_probe

// ===== test/dsudbg_top_props.sv
/*
  Checker for the service unit top ports.
  Assumes it is bound to every dsudbg_top instance.
*/
`timescale 1ns/10ps
module dsudbg_top_props
  import dsudbg_pkg::*;
(
  // clocks and resets
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic swclk,
  input wire logic ext_reset_pin_n,
  // pins and state
  input wire logic swdio_oe,
  input wire logic idle_mode,
  input wire logic cpu_reset_hold,
  input wire logic swclk_owned,
  // read channels
  input wire logic [DSUDBG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [DSUDBG_ADDR_W-1:0] ar_r;
  wire logic rd_cid;
  // address of the read under way
  assign rd_cid = ar_r[DSUDBG_ADDR_W-1:2] == DSUDBG_COMPONENT_IDENT_ONE_OFS[DSUDBG_ADDR_W-1:2];
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      ar_r <= '0;
    else if (s_axi_arvalid && s_axi_arready)
      ar_r <= s_axi_araddr;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_ack;
    swdio_oe [*3];
  endsequence
  property p_own_rst;
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n) |-> swclk_owned && cpu_reset_hold;
  endproperty
  property p_own_ext;
    @(posedge ref_clk) disable iff (!reset_n)
    !ext_reset_pin_n [*4] |-> swclk_owned && cpu_reset_hold;
  endproperty
  property p_idle;
    @(posedge ref_clk) disable iff (!reset_n)
    idle_mode && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_class;
    @(posedge ref_clk) disable iff (!reset_n)
    s_axi_rvalid && rd_cid |-> s_axi_rdata[7:4] == DSUDBG_COMPONENT_CLASS_FIELD_ROM;
  endproperty
  property p_pre;
    @(posedge ref_clk) disable iff (!reset_n)
    s_axi_rvalid && rd_cid |-> s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:8] == 24'h0;
  endproperty
  property p_turn;
    @(posedge swclk) disable iff (!reset_n)
    $rose(swdio_oe) |-> s_ack;
  endproperty
  property p_rone;
    @(posedge ref_clk) disable iff (!reset_n)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_own_rst: assert property (p_own_rst) else $error("pin not owned after reset");
  a_own_ext: assert property (p_own_ext) else $error("pin not owned in ext reset");
  a_idle: assert property (p_idle) else $error("no read answer in idle");
  a_class: assert property (p_class) else $error("class field wrong");
  a_pre: assert property (p_pre) else $error("preamble field wrong");
  a_turn: assert property (p_turn) else $error("answer shorter than ack");
  a_rone: assert property (p_rone) else $error("read data held after take");
endmodule // dsudbg_top_props
bind dsudbg_top dsudbg_top_props chk (.ref_clk, .reset_n, .swclk, .ext_reset_pin_n,
  .swdio_oe, .idle_mode, .cpu_reset_hold, .swclk_owned, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// ===== test/test_device_service_debug_port.sv
/*
  Self-checking bench for the service unit top.
  Assumes the probe model and the bound checker.
*/
`timescale 1ns/10ps
module test_device_service_debug_port;
  import dsudbg_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, ext_n = 1'b1, remap = 1'b0, sel_en = 1'b1;
  logic idle = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, d;
  logic [1:0] r;
  logic [39:0] got;
  logic [5:0] n;
  wire logic swclk, swdio_in, swdio_out, swdio_oe, hold, owned;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int failures = 0, samples_checked = 0, cycles = 0;
  localparam logic [45:0] ROWS [6] = '{
    {DSUDBG_COMPONENT_IDENT_ONE_OFS, DSUDBG_COMPONENT_IDENT_ONE_VALUE, DSUDBG_RESP_OKAY},
    {12'h00A, DSUDBG_COMPONENT_IDENT_ONE_VALUE, DSUDBG_RESP_OKAY},
    {DSUDBG_CTRL_OFS, 32'h00000000, DSUDBG_RESP_OKAY},
    {DSUDBG_STATUS_OFS, 32'h0000000E, DSUDBG_RESP_OKAY},
    {12'h00C, 32'h00000000, DSUDBG_RESP_SLVERR},
    {12'hFFC, 32'h00000000, DSUDBG_RESP_SLVERR}};
  localparam logic [31:0] LOST [2] = '{32'h00000018, 32'h0000001C};
  always #5 ref_clk = ~ref_clk;
  dsudbg_probe probe (.swclk(swclk), .swdio_in(swdio_in), .swdio_out(swdio_out),
    .swdio_oe(swdio_oe));
  dsudbg_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .ext_reset_pin_n(ext_n),
    .swclk(swclk), .swdio_in(swdio_in), .swdio_out(swdio_out), .swdio_oe(swdio_oe),
    .pin_function_remapped(remap), .pin_function_select_en(sel_en), .idle_mode(idle),
    .cpu_reset_hold(hold), .swclk_owned(owned), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ////////////////////////////////////////////////////////////////////////////
  task summarize;
  begin
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] e, input string what);
  begin
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t %s", $time, what);
    end
  end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic done;
  begin
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(posedge ref_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  end
  endtask
  task automatic rd(input logic [11:0] a);
    logic done;
  begin
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(posedge ref_clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  end
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd(ROWS[i][45:34]);
      chk({d, r}, ROWS[i][33:0], "register read");
    end
    wr(DSUDBG_COMPONENT_IDENT_ONE_OFS, 32'hFFFFFFFF);
    chk(r, DSUDBG_RESP_OKAY, "ident write response");
    rd(DSUDBG_COMPONENT_IDENT_ONE_OFS);
    chk({d, r}, {DSUDBG_COMPONENT_IDENT_ONE_VALUE, DSUDBG_RESP_OKAY}, "ident after write");
    chk(hold, 1'b1, "cold plug hold");
    wr(DSUDBG_CTRL_OFS, 32'h00000001);
    chk({hold, owned}, 2'h1, "hold release");
    probe.frame(1'b1, got, n);
    chk({n, got[35:0]}, {6'h24, ^DSUDBG_COMPONENT_IDENT_ONE_VALUE, DSUDBG_COMPONENT_IDENT_ONE_VALUE, 3'h1}, "read frame");
    rd(DSUDBG_STATUS_OFS);
    chk(d, 32'h0000000B, "probe seen");
    wr(DSUDBG_STATUS_OFS, 32'h00000001);
    idle <= 1'b1;
    probe.frame(1'b0, got, n);
    chk({n, got[2:0]}, {6'h03, 3'h4}, "write frame");
    rd(DSUDBG_STATUS_OFS);
    chk(d, 32'h0000001B, "idle status");
    for (int k = 0; k < 2; k++)
    begin
      wr(DSUDBG_STATUS_OFS, 32'h00000001);
      remap <= (k == 0);
      sel_en <= (k == 0);
      repeat (4) @(posedge ref_clk);
      chk(owned, 1'b0, "pin still owned");
      remap <= 1'b0;
      sel_en <= 1'b1;
      probe.frame(1'b1, got, n);
      rd(DSUDBG_STATUS_OFS);
      chk(d, LOST[k], "hot-plug not lost");
      ext_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk({hold, owned}, 2'h3, "external reset");
      ext_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      probe.frame(1'b1, got, n);
      rd(DSUDBG_STATUS_OFS);
      chk(d, 32'h0000001F, "hot-plug not back");
    end
    reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(DSUDBG_STATUS_OFS);
    chk(d, 32'h0000001E, "status after reset");
    summarize();
  end
endmodule // test_device_service_debug_port

// ===== verilog/dsudbg_link_front.sv
/*
  Link-clock front end: watches the probe data line on the probe clock,
  flags line resets as probe arrivals while hot-plug is enabled and answers read requests with the
  ident word.  Everything here samples and drives on the rising probe clock.
  Assumes the probe clock may stop between frames.
*/
`timescale 1ns/10ps
module dsudbg_link_front
  import dsudbg_pkg::*;
(
  // link clock and reset
  input wire logic swclk,
  input wire logic reset_n,
  // data pin
  input wire logic swdio_in,
  output logic swdio_out,
  output logic swdio_oe,
  // core side
  dsudbg_link_if.link lk
);
  import dsudbg_pkg::*;
  dsudbg_link_state_t state_r;
  logic [5:0] ones_r;
  logic [5:0] cnt_r;
  logic [6:0] req_r;
  logic [32:0] shift_r;
  logic [2:0] ack_r;
  logic is_read_r;
  logic armed_r;
  logic en_meta_r;
  logic en_sync_r;
  logic probe_tgl_r;
  ////////////////////////////////////////////////////////////////////////////
  wire line_reset = (ones_r >= DSUDBG_LINE_RESET_ONES);
  // request bits: apndp, rnw, a2, a3, parity, stop, park (lsb first)
  wire [6:0] req_full = {swdio_in, req_r[6:1]};
  wire req_rnw = req_full[1];
  wire req_good = (^req_full[4:0] == 1'b0) && !req_full[5] && req_full[6];
  wire [32:0] ident_frame = {^lk.ident_word, lk.ident_word};
  assign lk.probe_tgl = probe_tgl_r;
  always_ff @(posedge swclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      en_meta_r <= 1'b0;
      en_sync_r <= 1'b0;
      ones_r <= '0;
      probe_tgl_r <= 1'b0;
      armed_r <= 1'b0;
    end
    else
    begin
      en_meta_r <= lk.hotplug_en;
      en_sync_r <= en_meta_r;
      ones_r <= swdio_in ? (line_reset ? ones_r : ones_r + 6'h01) : 6'h00;
      if (line_reset && !swdio_in)
      begin
        armed_r <= 1'b1;
        if (en_sync_r)
          probe_tgl_r <= ~probe_tgl_r;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // request / acknowledge / data sequencer
  always_ff @(posedge swclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= DSUDBG_ST_WAIT;
      cnt_r <= '0;
      req_r <= '0;
      shift_r <= '0;
      ack_r <= '0;
      is_read_r <= 1'b0;
      swdio_out <= 1'b0;
      swdio_oe <= 1'b0;
    end
    else if (line_reset)
    begin
      state_r <= DSUDBG_ST_WAIT;
      swdio_oe <= 1'b0;
    end
    else
    begin
      case (state_r)
        DSUDBG_ST_WAIT:
          if (armed_r && swdio_in)
          begin
            state_r <= DSUDBG_ST_REQ;
            cnt_r <= '0;
          end
        DSUDBG_ST_REQ:
        begin
          req_r <= req_full;
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == DSUDBG_REQ_BITS - 6'h01)
          begin
            state_r <= req_good ? DSUDBG_ST_TURN : DSUDBG_ST_WAIT;
            is_read_r <= req_rnw;
            ack_r <= req_rnw ? DSUDBG_ACK_OK : DSUDBG_ACK_FAULT;
          end
        end
        DSUDBG_ST_TURN:
        begin
          state_r <= DSUDBG_ST_ACK;
          cnt_r <= '0;
          swdio_oe <= 1'b1;
          swdio_out <= ack_r[0];
          ack_r <= {1'b0, ack_r[2:1]};
        end
        DSUDBG_ST_ACK:
        begin
          cnt_r <= cnt_r + 6'h01;
          swdio_out <= ack_r[0];
          ack_r <= {1'b0, ack_r[2:1]};
          if (cnt_r == DSUDBG_ACK_BITS - 6'h02)
          begin
            state_r <= is_read_r ? DSUDBG_ST_DATA : DSUDBG_ST_BACK;
            shift_r <= ident_frame;
            cnt_r <= '0;
          end
        end
        DSUDBG_ST_DATA:
        begin
          swdio_out <= shift_r[0];
          shift_r <= {1'b0, shift_r[32:1]};
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == DSUDBG_DATA_BITS - 6'h01)
            state_r <= DSUDBG_ST_BACK;
        end
        DSUDBG_ST_BACK:
        begin
          swdio_oe <= 1'b0;
          swdio_out <= 1'b0;
          state_r <= DSUDBG_ST_WAIT;
        end
        default:
        begin
          state_r <= DSUDBG_ST_WAIT;
          swdio_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule // dsudbg_link_front

// ===== verilog/dsudbg_link_if.sv
/*
  Signals between the system-clock core and the link-clock front end.
  hotplug_en and ident_word are levels from the core; probe_tgl is a toggle
  from the link side and is synchronised by the core.
*/
`timescale 1ns/10ps
interface dsudbg_link_if;
  logic hotplug_en;
  logic [31:0] ident_word;
  logic probe_tgl;
  modport core (output hotplug_en, output ident_word, input probe_tgl);
  modport link (input hotplug_en, input ident_word, output probe_tgl);
endinterface

// ===== verilog/dsudbg_pkg.sv
/*
  Constants shared by the debug-port service unit: register map, ident value,
  link framing counts and state codes.
  Assumes a 100 MHz system clock and an AXI4-Lite register bus, 32-bit data.
*/
// Overview of operation
// - after reset the serial clock pin belongs to the service unit for probe detection
// - pin remapped or mux off disables hot-plug until power or external reset
// - the service unit keeps running while the device sits in Idle
// - ident-one bits 7:4 always read 0x1, the ROM-table class; writes ignored
// - ident-one bits 3:0 always read zero whatever else happens
// - pins are external reset input, probe serial clock, and one two-way data line
package dsudbg_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] DSUDBG_CTRL_OFS = 12'h000;
  localparam logic [11:0] DSUDBG_STATUS_OFS = 12'h004;
  localparam logic [11:0] DSUDBG_COMPONENT_IDENT_ONE_OFS = 12'h008;
  localparam int DSUDBG_ADDR_W = 12;
  // control fields (write-one actions)
  localparam int DSUDBG_CTRL_RELEASE_BIT = 0;
  // status fields
  localparam int DSUDBG_ST_PROBE_BIT = 0;
  localparam int DSUDBG_ST_HOTPLUG_BIT = 1;
  localparam int DSUDBG_ST_HOLD_BIT = 2;
  localparam int DSUDBG_ST_OWNED_BIT = 3;
  localparam int DSUDBG_ST_IDLE_BIT = 4;
  // ident-one fields
  localparam logic [3:0] DSUDBG_COMPONENT_CLASS_FIELD_ROM = 4'h1;
  localparam logic [3:0] DSUDBG_PREAMBLE = 4'h0;
  localparam logic [31:0] DSUDBG_COMPONENT_IDENT_ONE_VALUE = {24'h000000, DSUDBG_COMPONENT_CLASS_FIELD_ROM, DSUDBG_PREAMBLE};
  // bus responses
  localparam logic [1:0] DSUDBG_RESP_OKAY = 2'h0;
  localparam logic [1:0] DSUDBG_RESP_SLVERR = 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  // link framing
  localparam logic [5:0] DSUDBG_LINE_RESET_ONES = 6'h32;
  localparam logic [5:0] DSUDBG_REQ_BITS = 6'h07;
  localparam logic [5:0] DSUDBG_ACK_BITS = 6'h03;
  localparam logic [5:0] DSUDBG_DATA_BITS = 6'h21;
  localparam logic [2:0] DSUDBG_ACK_OK = 3'h1;
  localparam logic [2:0] DSUDBG_ACK_FAULT = 3'h4;
  localparam int DSUDBG_SYNC_W = 3;
  typedef enum logic [5:0] {
    DSUDBG_ST_WAIT = 6'h01,
    DSUDBG_ST_REQ = 6'h02,
    DSUDBG_ST_TURN = 6'h04,
    DSUDBG_ST_ACK = 6'h08,
    DSUDBG_ST_DATA = 6'h10,
    DSUDBG_ST_BACK = 6'h20
  } dsudbg_link_state_t;
endpackage

// ===== verilog/dsudbg_sync.sv
/*
  Two-flop synchroniser for a small group of independent levels.
  Assumes each bit is a slow level or a toggle; bits are not coherent.
*/
`timescale 1ns/10ps
module dsudbg_sync
  import dsudbg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // levels
  input wire logic [DSUDBG_SYNC_W-1:0] async_in,
  output logic [DSUDBG_SYNC_W-1:0] sync_out
);
  logic [DSUDBG_SYNC_W-1:0] meta_r;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // dsudbg_sync

// ===== verilog/dsudbg_top.sv
/*
  Debug-port service unit top: AXI4-Lite register slave, probe detection,
  CPU reset stretch, hot-plug enable and the link-clock front end.
  Assumes ext_reset_pin_n and swclk come from pins; pin mux and idle inputs
  come from logic on ref_clk.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module dsudbg_top
  import dsudbg_pkg::*;
(
  // system clock and power-on reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // device pins
  input wire logic ext_reset_pin_n,
  input wire logic swclk,
  input wire logic swdio_in,
  output logic swdio_out,
  output logic swdio_oe,
  // pin mux and power state
  input wire logic pin_function_remapped,
  input wire logic pin_function_select_en,
  input wire logic idle_mode,
  // system outputs
  output logic cpu_reset_hold,
  output logic swclk_owned,
  // axi4-lite write address
  input wire logic [DSUDBG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [DSUDBG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import dsudbg_pkg::*;
  dsudbg_link_if lk ();
  logic [DSUDBG_SYNC_W-1:0] sync_q;
  logic probe_tgl_d_r;
  logic hotplug_en_r;
  logic probe_seen_r;
  logic hold_r;
  logic decide_r;
  logic owned_r;
  logic [DSUDBG_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  ////////////////////////////////////////////////////////////////////////////
  // pin and toggle synchronisation
  dsudbg_sync u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in({lk.probe_tgl, swclk, ext_reset_pin_n}),
    .sync_out(sync_q)
  );
  wire ext_rst_n_s = sync_q[0];
  wire swclk_s = sync_q[1];
  wire probe_tgl_s = sync_q[2];
  wire probe_event = probe_tgl_s ^ probe_tgl_d_r;
  dsudbg_link_front u_front (
    .swclk(swclk),
    .reset_n(reset_n),
    .swdio_in(swdio_in),
    .swdio_out(swdio_out),
    .swdio_oe(swdio_oe),
    .lk(lk)
  );
  assign lk.hotplug_en = hotplug_en_r;
  assign lk.ident_word = DSUDBG_COMPONENT_IDENT_ONE_VALUE;
  assign cpu_reset_hold = hold_r;
  assign swclk_owned = owned_r;
  ////////////////////////////////////////////////////////////////////////////
  // write channel decode
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_ctrl = do_write && (awaddr_r == DSUDBG_CTRL_OFS);
  wire wr_status = do_write && (awaddr_r == DSUDBG_STATUS_OFS);
  wire wr_component_ident_one = do_write && (awaddr_r == DSUDBG_COMPONENT_IDENT_ONE_OFS);
  wire wr_mapped = wr_ctrl || wr_status || wr_component_ident_one;
  wire release_req = wr_ctrl && wstrb_r[0] && wdata_r[DSUDBG_CTRL_RELEASE_BIT];
  wire probe_clr = wr_status && wstrb_r[0] && wdata_r[DSUDBG_ST_PROBE_BIT];
  // read channel decode
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  // byte lane bits are ignored, as on the write side
  wire [DSUDBG_ADDR_W-1:0] ar_word = {s_axi_araddr[DSUDBG_ADDR_W-1:2], 2'b00};
  wire rd_ctrl = (ar_word == DSUDBG_CTRL_OFS);
  wire rd_status = (ar_word == DSUDBG_STATUS_OFS);
  wire rd_component_ident_one = (ar_word == DSUDBG_COMPONENT_IDENT_ONE_OFS);
  wire rd_mapped = rd_ctrl || rd_status || rd_component_ident_one;
  wire [31:0] status_word = {27'h0000000,
                             idle_mode,
                             owned_r,
                             hold_r,
                             hotplug_en_r,
                             probe_seen_r};
  wire [31:0] rd_word = rd_status ? status_word :
                        rd_component_ident_one ? DSUDBG_COMPONENT_IDENT_ONE_VALUE : 32'h00000000;
  // pin ownership as the mux currently stands
  wire pin_ours = !pin_function_remapped && pin_function_select_en;
  ////////////////////////////////////////////////////////////////////////////
  // idle_mode is only reported; no logic here is gated by it
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      probe_tgl_d_r <= 1'b0;
    else
      probe_tgl_d_r <= probe_tgl_s;
  end
  // pin ownership defaults to this unit out of reset
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      owned_r <= 1'b1;
    else if (!ext_rst_n_s)
      owned_r <= 1'b1;
    else
      owned_r <= pin_ours;
  end
  // hot-plug is lost for good once the pin leaves us, until a reset
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      hotplug_en_r <= 1'b1;
    else if (!ext_rst_n_s)
      hotplug_en_r <= 1'b1;
    else if (!pin_ours)
      hotplug_en_r <= 1'b0;
  end
  // probe seen: a new arrival beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      probe_seen_r <= 1'b0;
    else if (probe_event)
      probe_seen_r <= 1'b1;
    else if (probe_clr)
      probe_seen_r <= 1'b0;
  end
  // cold-plug: a probe holds swclk low across reset release to stretch the cpu
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold_r <= 1'b1;
      decide_r <= 1'b1;
    end
    else if (!ext_rst_n_s)
    begin
      hold_r <= 1'b1;
      decide_r <= 1'b1;
    end
    else if (decide_r)
    begin
      hold_r <= owned_r && !swclk_s;
      decide_r <= 1'b0;
    end
    else if (release_req)
      hold_r <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data taken in either order
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DSUDBG_RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else
    begin
      if (aw_hs)
      begin
        awaddr_r <= {s_axi_awaddr[DSUDBG_ADDR_W-1:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (w_hs)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? DSUDBG_RESP_OKAY : DSUDBG_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path: data one cycle after the address is taken
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= DSUDBG_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_mapped ? DSUDBG_RESP_OKAY : DSUDBG_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // dsudbg_top
